// file: sim/p4s_tug2_adapt_sink_tb.sv
/*
  self-checking bench for the p4s to tug-2 sink adaptation.
  assumes hready tied to hreadyout and a short 24-bit frame with the
  label byte at bit 8, so a frame lasts 600 hclk.
*/
`timescale 1ns/1ps
module p4s_tug2_adapt_sink_tb
  import pts_pkg::*;
;
  typedef struct {
    logic        act;
    logic [2:0]  lab;
    logic        tsf;
    logic [31:0] st;
    logic        pc;
    logic        sf;
  } pts_row_type;

  logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        trail_fail_in = 1'b0, mf_err = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, label = 3'h3;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, p4s_clk, p4s_data, p4s_fs;
  logic        tug2_data, tug2_clk, tug2_fs, mfs, sf, tfa, plm_c, lom_c;
  logic [PTS_TU_SLOTS-1:0] tu_tf;
  int          n_mismatch = 0, tests_run = 0, cnt;

  // status = label<<8 | loss cause<<4 | plm cause<<3 | in mf<<2 | loss<<1 | plm
  pts_row_type rows [10] = '{
    '{1'b1, 3'h0, 1'b0, 32'h000D, 1'b1, 1'b1},
    '{1'b1, 3'h1, 1'b1, 32'h0105, 1'b0, 1'b1},
    '{1'b1, 3'h2, 1'b0, 32'h020D, 1'b1, 1'b1},
    '{1'b1, 3'h4, 1'b1, 32'h0405, 1'b0, 1'b1},
    '{1'b1, 3'h5, 1'b0, 32'h050D, 1'b1, 1'b1},
    '{1'b1, 3'h6, 1'b0, 32'h060D, 1'b1, 1'b1},
    '{1'b1, 3'h7, 1'b1, 32'h0705, 1'b0, 1'b1},
    '{1'b0, 3'h7, 1'b0, 32'h0000, 1'b0, 1'b1},
    '{1'b1, 3'h3, 1'b1, 32'h0304, 1'b0, 1'b0},
    '{1'b1, 3'h3, 1'b0, 32'h0304, 1'b0, 1'b0}
  };

  pts_adapt_sink #(
    .LOM_CYCLES (200),
    .MA_POS     (16'h0008)
  ) i_pts_adapt_sink (
    .hclk (hclk), .hresetn (hresetn), .hsel (hsel), .haddr (haddr),
    .htrans (htrans), .hwrite (hwrite), .hsize (hsize),
    .hwdata (hwdata), .hready (hreadyout), .hrdata (hrdata),
    .hreadyout (hreadyout), .hresp (hresp), .p4s_clk (p4s_clk),
    .p4s_data (p4s_data), .p4s_fs (p4s_fs),
    .trail_fail_in (trail_fail_in), .tug2_data (tug2_data),
    .tug2_clk (tug2_clk), .tug2_fs (tug2_fs),
    .multiframe_start_out (mfs), .server_fail_out (sf),
    .trail_fail_action (tfa), .tu_trail_fail (tu_tf),
    .payload_mismatch_cause (plm_c), .multiframe_loss_cause (lom_c)
  );

  pts_p4s_src #(
    .MA_POS     (8),
    .FRAME_BITS (24)
  ) i_pts_p4s_src (
    .label (label), .mf_err (mf_err), .p4s_clk (p4s_clk),
    .p4s_data (p4s_data), .p4s_fs (p4s_fs)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic give_up(input string nm);
    chk(nm, 32'h1, 32'h0);
    tally_and_finish();
  endtask : give_up

  // one single transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rdv = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 40) give_up("ahb_hready");
  endtask : ahb

  // returns just after the label byte of the next frame was judged
  task automatic next_frame(input int k);
    int n;
    repeat (k) begin
      n = 0;
      while (p4s_fs !== 1'b0 && n < 700) begin
        @(posedge hclk);
        n++;
      end
      while (p4s_fs !== 1'b1 && n < 700) begin
        @(posedge hclk);
        n++;
      end
      if (n >= 700) give_up("frame_start");
      repeat (425) @(posedge hclk);
    end
  endtask : next_frame

  // compare only when the pins read the same at both ends of the delay
  task automatic fwd_chk;
    logic [2:0] v;
    @(posedge hclk);
    v = {p4s_clk, p4s_data, p4s_fs};
    repeat (5) @(posedge hclk);
    if (v === {p4s_clk, p4s_data, p4s_fs}) begin
      chk("tug2_stream", {29'h0, v}, {29'h0, tug2_clk, tug2_data, tug2_fs});
    end
  endtask : fwd_chk

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("sf_tfa", 32'h3, {30'h0, sf, tfa});
    ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
    chk("status_inactive", 32'h0, rd);
    ahb(1'b0, PTS_ADDR_CTRL, 32'h0, rd);
    chk("ctrl_reset", 32'h0, rd);
    ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h0000_0008, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, PTS_ADDR_CTRL, 32'h1, rd);
    ahb(1'b0, PTS_ADDR_CTRL, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    next_frame(6);
    ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
    chk("status_aligned", 32'h0304, rd);
    // window of exactly eight frames holds two multiframe starts
    cnt = 0;
    repeat (4800) begin
      @(posedge hclk);
      if (mfs === 1'b1) begin
        cnt++;
        chk("mfs_on_fs", 32'h1, {31'h0, tug2_fs});
      end
    end
    chk("mfs_count", 32'h2, cnt);
    foreach (rows[i]) begin
      ahb(1'b1, PTS_ADDR_CTRL, {31'h0, rows[i].act}, rd);
      label <= rows[i].lab;
      trail_fail_in <= rows[i].tsf;
      next_frame(6);
      ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
      chk("status", rows[i].st, rd);
      chk("sf_tfa_plmc_lomc",
          {28'h0, rows[i].sf, rows[i].sf, rows[i].pc, 1'b0},
          {28'h0, sf, tfa, plm_c, lom_c});
      chk("tu_trail_fail", 32'h1,
          {31'h0, tu_tf === {PTS_TU_SLOTS{rows[i].sf}}});
      fwd_chk();
    end
    // one slipped code drops alignment; loss follows after the timer
    mf_err <= 1'b1;
    next_frame(1);
    mf_err <= 1'b0;
    // the held code only shows up as a repeat in the following frame
    next_frame(1);
    ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
    chk("status_oom", 32'h0300, rd);
    repeat (140) @(posedge hclk);
    chk("sf_early", 32'h0, {31'h0, sf});
    repeat (60) @(posedge hclk);
    chk("sf_tfa_plmc_lomc", 32'hD,
        {28'h0, sf, tfa, plm_c, lom_c});
    trail_fail_in <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("loss_cause_masked", 32'h0, {31'h0, lom_c});
    trail_fail_in <= 1'b0;
    // second good frame is judged while waiting, third on return
    next_frame(1);
    ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
    chk("status_three_good", 32'h0312, rd);
    next_frame(1);
    ahb(1'b0, PTS_ADDR_STATUS, 32'h0, rd);
    chk("status_realigned", 32'h0304, rd);
    chk("sf_cleared", 32'h0, {31'h0, sf});
    tally_and_finish();
  end
endmodule : p4s_tug2_adapt_sink_tb

// file: sim/pts_p4s_src.sv
/*
  partner model: the p4s trail termination sink feeding the adaptation.
  assumes a free-running link clock and frames sent back to back.
*/
`timescale 1ns/1ps
module pts_p4s_src #(
  parameter int MA_POS     = 8,
  parameter int FRAME_BITS = 24
) (
  // control from the bench
  input  wire logic [2:0] label,
  input  wire logic       mf_err,
  // p4s stream
  output logic            p4s_clk,
  output logic            p4s_data,
  output logic            p4s_fs
);
  int         bit_idx = 0;
  logic [1:0] mf_code = 2'h0;
  logic [7:0] ma_byte = 8'h00;

  // 1 ns offset keeps link edges clear of hclk edges
  initial begin
    p4s_clk = 1'b0;
    p4s_data = 1'b0;
    p4s_fs = 1'b0;
    #1;
    forever #62.5 p4s_clk = ~p4s_clk;
  end

  // change on the falling edge, away from the sampling edge
  always @(negedge p4s_clk) begin
    if (bit_idx == 0) begin
      ma_byte = {2'h0, label, mf_code, 1'b0};
      if (mf_err !== 1'b1) begin
        mf_code = mf_code + 2'h1;
      end
    end
    p4s_fs <= (bit_idx == 0);
    if (bit_idx >= MA_POS && bit_idx < MA_POS + 8) begin
      p4s_data <= ma_byte[7 - (bit_idx - MA_POS)];
    end else begin
      p4s_data <= bit_idx[0] ^ bit_idx[2];
    end
    bit_idx = (bit_idx == FRAME_BITS - 1) ? 0 : bit_idx + 1;
  end
endmodule : pts_p4s_src

// file: verilog/pts_adapt_sink.sv
/*
  p4s to tug-2 sink adaptation: label check, multiframe alignment,
  defects, fault causes, server fail and an ahb-lite register port.
  assumes the p4s clock, data, frame start and trail fail arrive from
  another domain and are far slower than hclk.
*/
// Notes on behaviour
// - accepted label bits 3-5 compared with 011
// - mismatch defect from accepted label comparison
// - recover 500 us phase from bits 6-7
// - single sequence error drops to out-of-multiframe
// - in-multiframe after four error-free frames
// - inactive: server fail high, status suppressed
// - loss defect after fixed time out-of-multiframe
// - loss defect clears on re-entering in-multiframe
// - server fail from mismatch or loss defect
// - mismatch cause: defect and no trail fail
// - loss cause: loss, no trail fail, no mismatch
// - sinks addressed by l 1-20, m 0-3
// - several sinks may read one timeslot
`timescale 1ns/1ps
module pts_adapt_sink
  import pts_pkg::*;
#(
  parameter int unsigned LOM_CYCLES = PTS_LOM_CYCLES,
  parameter logic [15:0] MA_POS     = PTS_MA_POS
) (
  // system
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // p4s path side, asynchronous to hclk
  input  wire logic                    p4s_clk,
  input  wire logic                    p4s_data,
  input  wire logic                    p4s_fs,
  input  wire logic                    trail_fail_in,
  // tug-2 side
  output logic                         tug2_data,
  output logic                         tug2_clk,
  output logic                         tug2_fs,
  output logic                         multiframe_start_out,
  output logic                         server_fail_out,
  output logic                         trail_fail_action,
  output logic [PTS_TU_SLOTS-1:0]      tu_trail_fail,
  // management
  output logic                         payload_mismatch_cause,
  output logic                         multiframe_loss_cause
);

  localparam int              LW       = $clog2(LOM_CYCLES + 1);
  localparam logic [LW-1:0]   LOM_LAST = LW'(LOM_CYCLES - 1);
  localparam logic [15:0]     MA_LAST  = MA_POS + 16'h0007;

  typedef struct packed {
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_prev;
    logic        d_s1;
    logic        d_s2;
    logic        fs_s1;
    logic        fs_s2;
    logic        tsf_s1;
    logic        tsf_s2;
    logic [15:0] bit_cnt;
    logic [7:0]  ma_sh;
    logic [2:0]  lbl_cand;
    logic [2:0]  lbl_cnt;
    logic [2:0]  lbl_acc;
    logic        plm;
    logic [1:0]  mf_exp;
    logic [2:0]  good_cnt;
    pts_mf_type  mf_state;
    logic [LW-1:0] lom_cnt;
    logic        lom;
    logic        fwd_d;
    logic        fwd_ck;
    logic        fwd_fs;
    logic        mfs;
    logic        ssf;
    logic        plm_c;
    logic        lom_c;
    logic        active;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
  } pts_state_type;

  localparam pts_state_type RESET_STATE = '{
    lbl_cand:  PTS_LABEL_EXP,
    lbl_acc:   PTS_LABEL_EXP,
    mf_state:  PTS_OOM,
    ssf:       1'h1,
    active:    PTS_CTRL_ACTIVE_RST,
    ready:     1'h1,
    default:   '0
  };

  pts_state_type state_reg;
  pts_state_type state_next;

  logic        link_rise;
  logic        ma_done;
  logic [7:0]  ma_byte;
  logic [1:0]  ma_code;
  logic [2:0]  ma_label;
  logic        take;

  pts_tug2_if link_if ();

  always_comb begin
    state_next = state_reg;
    // link inputs: the first stage feeds only the second
    state_next.ck_s1   = p4s_clk;
    state_next.ck_s2   = state_reg.ck_s1;
    state_next.ck_prev = state_reg.ck_s2;
    state_next.d_s1    = p4s_data;
    state_next.d_s2    = state_reg.d_s1;
    state_next.fs_s1   = p4s_fs;
    state_next.fs_s2   = state_reg.fs_s1;
    state_next.tsf_s1  = trail_fail_in;
    state_next.tsf_s2  = state_reg.tsf_s1;
    link_rise = state_reg.ck_s2 & ~state_reg.ck_prev;

    // stream forwarded with equal delay on all three
    state_next.fwd_d  = state_reg.d_s2;
    state_next.fwd_ck = state_reg.ck_s2;
    state_next.fwd_fs = state_reg.fs_s2;

    // bit position within the frame and label byte capture
    ma_done   = 1'h0;
    ma_byte   = {state_reg.ma_sh[6:0], state_reg.d_s2};
    ma_code   = ma_byte[2:1];
    ma_label  = ma_byte[5:3];
    state_next.mfs = 1'h0;
    if (link_rise) begin
      state_next.bit_cnt = state_reg.fs_s2 ? 16'h0000
                                           : state_reg.bit_cnt + 16'h0001;
      state_next.ma_sh   = ma_byte;
      ma_done = (state_next.bit_cnt == MA_LAST);
      // pulse at the frame that opens the multiframe
      if (state_reg.fs_s2 && state_reg.mf_state == PTS_IM &&
          state_reg.mf_exp == 2'h0) begin
        state_next.mfs = 1'h1;
      end
    end

    if (ma_done) begin
      // label acceptance: same code in consecutive frames
      if (ma_label == state_reg.lbl_cand) begin
        if (state_reg.lbl_cnt != PTS_LABEL_ACCEPT) begin
          state_next.lbl_cnt = state_reg.lbl_cnt + 3'h1;
        end
        if (state_reg.lbl_cnt == PTS_LABEL_ACCEPT - 3'h1) begin
          state_next.lbl_acc = ma_label;
        end
      end else begin
        state_next.lbl_cand = ma_label;
        state_next.lbl_cnt  = 3'h1;
      end
      // multiframe alignment on the two-bit sequence
      if (ma_code == state_reg.mf_exp) begin
        if (state_reg.good_cnt != PTS_MF_GOOD) begin
          state_next.good_cnt = state_reg.good_cnt + 3'h1;
        end
        if (state_reg.good_cnt == PTS_MF_GOOD - 3'h1) begin
          state_next.mf_state = PTS_IM;
        end
      end else begin
        state_next.mf_state = PTS_OOM;
        state_next.good_cnt = 3'h1;
      end
      state_next.mf_exp = ma_code + 2'h1;
    end

    state_next.plm = (state_next.lbl_acc != PTS_LABEL_EXP);

    // loss timer: runs on hclk so it keeps going if the link stops
    case (state_next.mf_state)
      PTS_IM: begin
        state_next.lom     = 1'h0;
        state_next.lom_cnt = '0;
      end
      PTS_OOM: begin
        if (state_reg.lom_cnt == LOM_LAST) begin
          state_next.lom = 1'h1;
        end else begin
          state_next.lom_cnt = state_reg.lom_cnt + LW'(1);
        end
      end
      default: begin
        state_next.mf_state = PTS_OOM;
      end
    endcase

    // ahb-lite: zero wait states, always okay
    take = hsel & hready & htrans[PTS_HTRANS_ACTIVE_BIT];
    state_next.wr_pend = take & hwrite;
    state_next.wr_addr = haddr;
    state_next.ready   = 1'h1;
    state_next.resp    = 1'h0;
    if (state_reg.wr_pend && state_reg.wr_addr == PTS_ADDR_CTRL) begin
      state_next.active = hwdata[PTS_CTRL_ACTIVE_BIT];
    end

    // consequent action and correlations
    state_next.ssf   = ~state_next.active | state_next.plm |
                       state_next.lom;
    state_next.plm_c = state_next.active & state_next.plm &
                       ~state_next.tsf_s2;
    state_next.lom_c = state_next.active & state_next.lom &
                       ~state_next.tsf_s2 & ~state_next.plm;

    // read data for the next data phase; a write still in its data
    // phase is forwarded so a back-to-back read sees it
    state_next.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr)
        PTS_ADDR_CTRL: begin
          state_next.rdata[PTS_CTRL_ACTIVE_BIT] = state_next.active;
        end
        PTS_ADDR_STATUS: begin
          if (state_reg.active) begin
            state_next.rdata[PTS_ST_PLM_DEF]   = state_reg.plm;
            state_next.rdata[PTS_ST_LOM_DEF]   = state_reg.lom;
            state_next.rdata[PTS_ST_IN_MF]     =
              (state_reg.mf_state == PTS_IM);
            state_next.rdata[PTS_ST_PLM_CAUSE] = state_reg.plm_c;
            state_next.rdata[PTS_ST_LOM_CAUSE] = state_reg.lom_c;
            state_next.rdata[PTS_ST_LABEL_LSB +: 3] = state_reg.lbl_acc;
          end
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link_if.d   = state_reg.fwd_d;
  assign link_if.ck  = state_reg.fwd_ck;
  assign link_if.fs  = state_reg.fwd_fs;
  assign link_if.mfs = state_reg.mfs;
  assign link_if.ssf = state_reg.ssf;

  pts_tug2_term u_term (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .up                   (link_if.term),
    .tug2_data            (tug2_data),
    .tug2_clk             (tug2_clk),
    .tug2_fs              (tug2_fs),
    .multiframe_start_out (multiframe_start_out),
    .trail_fail_action    (trail_fail_action),
    .tu_trail_fail        (tu_trail_fail)
  );

  assign hrdata                 = state_reg.rdata;
  assign hreadyout              = state_reg.ready;
  assign hresp                  = state_reg.resp;
  assign server_fail_out        = state_reg.ssf;
  assign payload_mismatch_cause = state_reg.plm_c;
  assign multiframe_loss_cause  = state_reg.lom_c;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_label_check: assert property (
    $changed(state_reg.lbl_acc) |->
      state_reg.plm == (state_reg.lbl_acc != PTS_LABEL_EXP))
    else $error("mismatch defect not tied to accepted label");
  a_label_accept: assert property (
    $changed(state_reg.lbl_acc) |->
      $past(state_reg.lbl_cnt) == PTS_LABEL_ACCEPT - 3'h1)
    else $error("label accepted without enough repeats");
  a_mf_phase: assert property (
    state_reg.mfs |-> $past(state_reg.mf_exp) == 2'h0 &&
      $past(state_reg.mf_state) == PTS_IM ##1
      !state_reg.mfs)
    else $error("multiframe start off phase");
  a_oom_on_error: assert property (
    ma_done && ma_code != state_reg.mf_exp |=>
      state_reg.mf_state == PTS_OOM)
    else $error("sequence error did not drop alignment");
  a_im_four: assert property (
    $rose(state_reg.mf_state == PTS_IM) |->
      $past(state_reg.good_cnt) == 3'h3)
    else $error("alignment gained without four good frames");
  a_inactive_off: assert property (
    !state_reg.active |-> server_fail_out && !payload_mismatch_cause &&
      !multiframe_loss_cause)
    else $error("inactive block still reports");
  a_lom_declare: assert property (
    $rose(state_reg.lom) |-> state_reg.lom_cnt == LOM_LAST &&
      $past(state_reg.mf_state) == PTS_OOM)
    else $error("loss defect raised at wrong time");
  a_lom_clear: assert property (
    state_reg.mf_state == PTS_IM |-> !state_reg.lom)
    else $error("loss defect held in multiframe");
  a_ssf_defect: assert property (
    (state_reg.plm || state_reg.lom) |-> server_fail_out ##1
      trail_fail_action)
    else $error("defect did not raise server fail");
  a_plm_cause: assert property (
    payload_mismatch_cause |-> state_reg.plm && !state_reg.tsf_s2)
    else $error("mismatch cause without its conditions");
  a_lom_cause: assert property (
    multiframe_loss_cause |-> state_reg.lom && !state_reg.plm &&
      !state_reg.tsf_s2)
    else $error("loss cause without its conditions");
  a_fwd_stream: assert property (
    state_reg.fwd_d == $past(state_reg.d_s2) ##1
      tug2_data == $past(state_reg.fwd_d))
    else $error("stream not forwarded unchanged");

  c_gain_mf: cover property ($rose(state_reg.mf_state == PTS_IM));
  c_lose_mf: cover property ($rose(state_reg.lom));
  c_mismatch: cover property ($rose(payload_mismatch_cause));
  c_mf_start: cover property (multiframe_start_out);

endmodule : pts_adapt_sink

// file: verilog/pts_pkg.sv
/*
  constants, state enumeration and timeslot numbering for the p4s to
  tug-2 sink adaptation.
  assumes a 200 MHz hclk and a word-wide ahb-lite register port.
*/
package pts_pkg;

  // register byte addresses
  localparam logic [31:0] PTS_ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] PTS_ADDR_STATUS = 32'h0000_0004;

  // control fields and reset values
  localparam int          PTS_CTRL_ACTIVE_BIT = 0;
  localparam logic        PTS_CTRL_ACTIVE_RST = 1'h0;

  // status fields
  localparam int PTS_ST_PLM_DEF   = 0;
  localparam int PTS_ST_LOM_DEF   = 1;
  localparam int PTS_ST_IN_MF     = 2;
  localparam int PTS_ST_PLM_CAUSE = 3;
  localparam int PTS_ST_LOM_CAUSE = 4;
  localparam int PTS_ST_LABEL_LSB = 8;

  // label handling
  localparam logic [2:0]  PTS_LABEL_EXP    = 3'h3;
  localparam logic [2:0]  PTS_LABEL_ACCEPT = 3'h5;
  localparam logic [15:0] PTS_MA_POS       = 16'h0040;

  // multiframe alignment
  localparam logic [2:0]  PTS_MF_GOOD = 3'h4;

  // loss of multiframe time, inside the allowed 1 to 5 ms
  localparam longint PTS_LOM_TIME_US   = 64'd3000;
  localparam longint PTS_CLK_PERIOD_PS = 64'd5000;
  localparam int unsigned PTS_LOM_CYCLES =
    32'(PTS_LOM_TIME_US * 64'd1000000 / PTS_CLK_PERIOD_PS);

  // ahb transfer type bit that marks an active transfer
  localparam int PTS_HTRANS_ACTIVE_BIT = 1;

  // tu numbering: l = 1..20, m = 0 for tu-2 and 1..3 for tu-12
  localparam int PTS_TU_L_MAX = 20;
  localparam int PTS_TU_M_MAX = 3;
  localparam int PTS_TU_SLOTS = PTS_TU_L_MAX * (PTS_TU_M_MAX + 1);

  typedef enum logic [0:0] {
    PTS_OOM = 1'h0,
    PTS_IM  = 1'h1
  } pts_mf_type;

  function automatic int pts_tu_slot(input int l, input int m);
    return (l - 1) * (PTS_TU_M_MAX + 1) + m;
  endfunction : pts_tu_slot

endpackage : pts_pkg

// file: verilog/pts_tug2_if.sv
/*
  carrier between the adaptation stage and the tug-2 termination stage.
  assumes both ends run on hclk.
*/
`timescale 1ns/1ps
interface pts_tug2_if;
  logic d;
  logic ck;
  logic fs;
  logic mfs;
  logic ssf;

  modport adapt (output d, output ck, output fs, output mfs, output ssf);
  modport term  (input  d, input  ck, input  fs, input  mfs, input  ssf);
endinterface : pts_tug2_if

// file: verilog/pts_tug2_term.sv
/*
  tug-2 termination stage: turns server fail into trail fail, fans that
  out to every lower-order sink timeslot and passes the stream through.
  assumes the adaptation stage drives the carrier from flip-flops.
*/
`timescale 1ns/1ps
module pts_tug2_term
  import pts_pkg::*;
(
  // system
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // from the adaptation stage
  pts_tug2_if.term                     up,
  // toward the lower-order sinks
  output logic                         tug2_data,
  output logic                         tug2_clk,
  output logic                         tug2_fs,
  output logic                         multiframe_start_out,
  output logic                         trail_fail_action,
  output logic [PTS_TU_SLOTS-1:0]      tu_trail_fail
);

  typedef struct packed {
    logic                    d;
    logic                    ck;
    logic                    fs;
    logic                    mfs;
    logic                    tsf;
    logic [PTS_TU_SLOTS-1:0] tu_fail;
  } pts_term_type;

  pts_term_type t_reg;
  pts_term_type t_next;

  always_comb begin
    t_next     = t_reg;
    t_next.d   = up.d;
    t_next.ck  = up.ck;
    t_next.fs  = up.fs;
    t_next.mfs = up.mfs;
    t_next.tsf = up.ssf;
    // every sink sees the same slot at once, no arbitration
    for (int l = 1; l <= PTS_TU_L_MAX; l++) begin
      for (int m = 0; m <= PTS_TU_M_MAX; m++) begin
        t_next.tu_fail[pts_tu_slot(l, m)] = up.ssf;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_reg <= '{tsf: 1'h1, tu_fail: '1, default: '0};
    end else begin
      t_reg <= t_next;
    end
  end

  assign tug2_data            = t_reg.d;
  assign tug2_clk             = t_reg.ck;
  assign tug2_fs              = t_reg.fs;
  assign multiframe_start_out = t_reg.mfs;
  assign trail_fail_action    = t_reg.tsf;
  assign tu_trail_fail        = t_reg.tu_fail;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tsf_follow: assert property (
    trail_fail_action == $past(up.ssf) && tu_trail_fail[0] == $past(up.ssf))
    else $error("trail fail does not follow server fail");
  a_pass_stream: assert property (
    tug2_data == $past(up.d) && tug2_fs == $past(up.fs))
    else $error("tug-2 stream altered in termination stage");

endmodule : pts_tug2_term
